//--- shared/symbol_port_pkg.sv
// shared constants and types for the symbol mode data port
package symbol_port_pkg;

  // symbol width and its split over the pins
  localparam int SYM_W = 5;
  localparam int SYM_LOW_W = 4;
  localparam int SYM_MSB = 4;

  // symbol clock rate and the reference that feeds the divider
  localparam int SYM_CLK_MHZ = 25;
  localparam int REF_DIV = 2;
  localparam int REF_CLK_MHZ = SYM_CLK_MHZ * REF_DIV;

  // core clock, for the record of how the two rates relate
  localparam int CORE_CLK_MHZ = 20;
  localparam int SYM_PERIOD_NS = 40;
  localparam int CORE_PERIOD_NS = 50;
  // core cycles that one symbol period spans, least time rounded up
  localparam int SYM_PERIOD_CORE_CYC =
    (SYM_PERIOD_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

  // management address that forces the data outputs to float
  localparam logic [4:0] FLOAT_ADDR = 5'h00;
  localparam int ADDR_W = 5;

  // value the receive lines show before the first symbol arrives
  localparam logic [4:0] IDLE_SYM = 5'h1f;

  // level of the unused framing outputs
  localparam logic UNUSED_LEVEL = 1'b0;

  // receive pin group: bit 4 leaves on the pin otherwise used for errors
  typedef struct packed {
    logic msb;
    logic [3:0] low;
  } rx_pins_t;

  // transmit pin group: bit 4 arrives on the pin otherwise used for errors
  typedef struct packed {
    logic msb;
    logic [3:0] low;
  } tx_pins_t;

endpackage

//--- hdl/symbol_skid_buffer.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module symbol_skid_buffer #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  initial begin
    if (DEPTH != 2) begin
      $error("symbol_skid_buffer supports a depth of two only");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic [1:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      count <= 2'h0;
      in_ready <= 1'b0;
    end else begin
      count <= next_count;
      // registered ready: full is known one cycle ahead from next_count
      in_ready <= (next_count != 2'h2);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule

//--- hdl/symbol_mode_data_port.sv
// symbol mode data port: raw 5-bit symbols between media side and link pins
//
// Summary of operation
// - receive symbol clock is made at 25 MHz and times the receive lines
// - receive symbol is 5 bits, line 0 least and line 4 most significant
// - received symbols go to the receive lines continuously, frame or not
// - receive data valid is never asserted in this mode
// - receive lines change only on rising edges of the receive clock
// - transmit symbol is 5 bits, line 0 least and line 4 most significant
// - all transmit lines sampled on every transmit clock rising edge
// - transmit enable is ignored; sampling never depends on it
// - float request high puts receive outputs in high impedance
// - management address zero also floats the data outputs
// - collision, receive valid and transmit enable pins are unused
// - receive bit 4 leaves on the pin otherwise used for receive error
// - transmit symbol clock is made at 25 MHz
`timescale 1ns/1ps
module symbol_mode_data_port
  import symbol_port_pkg::*;
#(
  parameter int REF_MHZ = symbol_port_pkg::REF_CLK_MHZ,
  parameter int SYNC_STAGES = 2
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic sym_ref_clk,
  input wire logic [symbol_port_pkg::SYM_W-1:0] media_rx_symbol,
  input wire logic media_rx_valid,
  output logic media_rx_ready,
  output logic [symbol_port_pkg::SYM_W-1:0] media_tx_symbol,
  output logic media_tx_valid,
  output logic tx_overrun,
  input wire logic [symbol_port_pkg::ADDR_W-1:0] mgmt_address,
  input wire logic rx_output_float_request,
  output logic symbol_rx_clock,
  output logic symbol_rx_clock_oe,
  output symbol_port_pkg::rx_pins_t symbol_rx_bits,
  output logic symbol_rx_bits_oe,
  output logic symbol_tx_clock,
  input wire symbol_port_pkg::tx_pins_t symbol_tx_bits,
  input wire logic tx_enable_pin,
  output logic rx_data_valid_pin,
  output logic collision_pin
);
  import symbol_port_pkg::*;

  initial begin
    if (REF_MHZ != SYM_CLK_MHZ * REF_DIV) begin
      $error("reference clock must be twice the symbol clock");
    end
    if (SYNC_STAGES != 2) begin
      $error("only two synchroniser stages are supported");
    end
  end

  // ----------------------------------------------------------------
  // link side reset
  // ----------------------------------------------------------------
  logic lrst_meta;
  logic lrst_sync;
  logic lrst;

  always_ff @(posedge sym_ref_clk) begin
    lrst_meta <= srst;
    lrst_sync <= lrst_meta;
  end

  // retimed to the falling edge so link flops and checks agree on the first live rise
  always_ff @(negedge sym_ref_clk) begin
    lrst <= lrst_sync;
  end

  // ----------------------------------------------------------------
  // symbol clock divider
  // ----------------------------------------------------------------
  logic phase;
  logic sym_rise;

  // both symbol clocks come from this one flop, so rx and tx share phase
  assign sym_rise = !phase;

  always_ff @(posedge sym_ref_clk) begin
    if (lrst) begin
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
    end
  end

  assign symbol_rx_clock = phase;
  assign symbol_tx_clock = phase;

  // ----------------------------------------------------------------
  // float control
  // ----------------------------------------------------------------
  logic float_meta;
  logic float_sync;
  logic [ADDR_W-1:0] addr_meta;
  logic [ADDR_W-1:0] addr_sync;
  logic drive_en;

  always_ff @(posedge sym_ref_clk) begin
    float_meta <= rx_output_float_request;
    float_sync <= float_meta;
    addr_meta <= mgmt_address;
    addr_sync <= addr_meta;
  end

  assign drive_en = !float_sync && (addr_sync != FLOAT_ADDR);

  always_ff @(posedge sym_ref_clk) begin
    if (lrst) begin
      symbol_rx_bits_oe <= 1'b0;
      symbol_rx_clock_oe <= 1'b0;
    end else begin
      symbol_rx_bits_oe <= drive_en;
      symbol_rx_clock_oe <= drive_en;
    end
  end

  // ----------------------------------------------------------------
  // unused framing pins
  // ----------------------------------------------------------------
  always_ff @(posedge sym_ref_clk) begin
    if (lrst) begin
      rx_data_valid_pin <= UNUSED_LEVEL;
      collision_pin <= UNUSED_LEVEL;
    end else begin
      rx_data_valid_pin <= UNUSED_LEVEL;
      collision_pin <= UNUSED_LEVEL;
    end
  end

  // ----------------------------------------------------------------
  // receive path, core side: buffer then toggle handshake
  // ----------------------------------------------------------------
  logic [SYM_W-1:0] buf_data;
  logic buf_valid;
  logic buf_ready;
  logic [SYM_W-1:0] rx_hold;
  logic rx_req;
  logic rx_ack_meta;
  logic rx_ack_sync;
  logic rx_idle;
  logic rx_ack_link;

  symbol_skid_buffer #(
    .WIDTH(SYM_W),
    .DEPTH(2)
  ) u_rx_buf (
    .core_clk(core_clk),
    .srst(srst),
    .in_data(media_rx_symbol),
    .in_valid(media_rx_valid),
    .in_ready(media_rx_ready),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(buf_ready)
  );

  // a new word is taken only once the link side acknowledged the last
  assign rx_idle = (rx_ack_sync == rx_req);
  assign buf_ready = rx_idle;

  always_ff @(posedge core_clk) begin
    rx_ack_meta <= rx_ack_link;
    rx_ack_sync <= rx_ack_meta;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rx_req <= 1'b0;
      rx_hold <= IDLE_SYM;
    end else if (buf_valid && rx_idle) begin
      rx_req <= ~rx_req;
      rx_hold <= buf_data;
    end
  end

  // ----------------------------------------------------------------
  // receive path, link side
  // ----------------------------------------------------------------
  logic rx_req_meta;
  logic rx_req_sync;
  logic [SYM_W-1:0] cur_sym;
  logic rx_new;

  always_ff @(posedge sym_ref_clk) begin
    rx_req_meta <= rx_req;
    rx_req_sync <= rx_req_meta;
  end

  assign rx_new = (rx_req_sync != rx_ack_link);

  // rx_hold is stable while the toggle differs, so it is safe to take
  always_ff @(posedge sym_ref_clk) begin
    if (lrst) begin
      rx_ack_link <= 1'b0;
      cur_sym <= IDLE_SYM;
    end else if (rx_new) begin
      rx_ack_link <= ~rx_ack_link;
      cur_sym <= rx_hold;
    end
  end

  // last symbol is repeated if the media side falls behind
  always_ff @(posedge sym_ref_clk) begin
    if (lrst) begin
      symbol_rx_bits <= IDLE_SYM;
    end else if (sym_rise) begin
      symbol_rx_bits.low <= cur_sym[SYM_LOW_W-1:0];
      symbol_rx_bits.msb <= cur_sym[SYM_MSB];
    end
  end

  // ----------------------------------------------------------------
  // transmit path, link side
  // ----------------------------------------------------------------
  logic [SYM_W-1:0] tx_cap;
  logic tx_cap_new;
  logic [SYM_W-1:0] tx_hold;
  logic tx_req;
  logic tx_ack_meta;
  logic tx_ack_sync;
  logic tx_lost;
  logic tx_ack_core;

  // pins are launched on our own clock, so they are sampled without sync;
  // transmit enable is never looked at, nor is any symbol inserted
  always_ff @(posedge sym_ref_clk) begin
    if (lrst) begin
      tx_cap <= IDLE_SYM;
      tx_cap_new <= 1'b0;
    end else begin
      tx_cap_new <= sym_rise;
      if (sym_rise) begin
        tx_cap <= {symbol_tx_bits.msb, symbol_tx_bits.low};
      end
    end
  end

  always_ff @(posedge sym_ref_clk) begin
    tx_ack_meta <= tx_ack_core;
    tx_ack_sync <= tx_ack_meta;
  end

  always_ff @(posedge sym_ref_clk) begin
    if (lrst) begin
      tx_req <= 1'b0;
      tx_hold <= IDLE_SYM;
      tx_lost <= 1'b0;
    end else if (tx_cap_new) begin
      if (tx_ack_sync == tx_req) begin
        tx_req <= ~tx_req;
        tx_hold <= tx_cap;
      end else begin
        // core too slow to drain: symbol dropped, flagged until reset
        tx_lost <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit path, core side
  // ----------------------------------------------------------------
  logic tx_req_meta;
  logic tx_req_sync;
  logic lost_meta;
  logic lost_sync;

  always_ff @(posedge core_clk) begin
    tx_req_meta <= tx_req;
    tx_req_sync <= tx_req_meta;
    lost_meta <= tx_lost;
    lost_sync <= lost_meta;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_ack_core <= 1'b0;
      media_tx_symbol <= IDLE_SYM;
      media_tx_valid <= 1'b0;
    end else begin
      media_tx_valid <= 1'b0;
      if (tx_req_sync != tx_ack_core) begin
        tx_ack_core <= ~tx_ack_core;
        media_tx_symbol <= tx_hold;
        media_tx_valid <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_overrun <= 1'b0;
    end else begin
      tx_overrun <= lost_sync;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [2:0] since_new;

  always_ff @(posedge sym_ref_clk) begin
    if (lrst) begin
      since_new <= 3'h0;
    end else if (rx_new) begin
      since_new <= 3'h1;
    end else if (since_new != 3'h0 && since_new != 3'h7) begin
      since_new <= since_new + 3'h1;
    end
  end

  sequence clk_rise_s;
    !symbol_rx_clock ##1 symbol_rx_clock;
  endsequence

  sequence clk_full_period_s;
    clk_rise_s ##1 !symbol_rx_clock ##1 symbol_rx_clock;
  endsequence

  a_clock_period_two: assert property (
    @(posedge sym_ref_clk) disable iff (lrst)
    (!symbol_rx_clock && $past(!lrst)) |-> ##1 symbol_rx_clock ##1 !symbol_rx_clock
  ) else $error("symbol clock does not run at half the reference");

  a_tx_clock_same: assert property (
    @(posedge sym_ref_clk) disable iff (lrst)
    clk_full_period_s |-> symbol_tx_clock == symbol_rx_clock
  ) else $error("transmit symbol clock departs from receive clock");

  a_rx_change_rise: assert property (
    @(posedge sym_ref_clk) disable iff (lrst)
    $changed(symbol_rx_bits) |-> $rose(symbol_rx_clock)
  ) else $error("receive lines changed away from a clock rise");

  a_rx_msb_pin: assert property (
    @(posedge sym_ref_clk) disable iff (lrst)
    sym_rise |=> {symbol_rx_bits.msb, symbol_rx_bits.low} == $past(cur_sym)
  ) else $error("receive symbol not presented with bit 4 on error pin");

  a_rx_forward_bound: assert property (
    @(posedge sym_ref_clk) disable iff (lrst)
    (since_new == 3'h3) |-> {symbol_rx_bits.msb, symbol_rx_bits.low} == cur_sym
  ) else $error("delivered symbol missing on receive lines");

  a_rxdv_never: assert property (
    @(posedge sym_ref_clk) disable iff (lrst)
    !rx_data_valid_pin && !collision_pin
  ) else $error("unused framing pin asserted");

  a_float_request: assert property (
    @(posedge sym_ref_clk) disable iff (lrst)
    float_sync |=> !symbol_rx_bits_oe && !symbol_rx_clock_oe
  ) else $error("receive outputs driven under float request");

  a_addr_zero_float: assert property (
    @(posedge sym_ref_clk) disable iff (lrst)
    (addr_sync == FLOAT_ADDR) |=> !symbol_rx_bits_oe
  ) else $error("data outputs driven at management address zero");

  a_drive_normal: assert property (
    @(posedge sym_ref_clk) disable iff (lrst)
    (!float_sync && addr_sync != FLOAT_ADDR) |=> symbol_rx_bits_oe
  ) else $error("receive outputs not driven with float request low");

  a_tx_sample_all: assert property (
    @(posedge sym_ref_clk) disable iff (lrst)
    sym_rise |=> tx_cap == $past({symbol_tx_bits.msb, symbol_tx_bits.low})
  ) else $error("transmit lines not sampled at clock rise");

  a_tx_no_enable: assert property (
    @(posedge sym_ref_clk) disable iff (lrst)
    sym_rise |=> tx_cap_new
  ) else $error("transmit sampling gated by transmit enable");

  a_tx_hold_only_rise: assert property (
    @(posedge sym_ref_clk) disable iff (lrst)
    !sym_rise |=> $stable(tx_cap)
  ) else $error("transmit capture changed between clock rises");

endmodule

//--- testbench/mac_symbol_model.sv
// behavioural far-end logic: takes raw receive symbols, supplies every transmit symbol
`timescale 1ns/1ps
module mac_symbol_model
  import symbol_port_pkg::*;
(
  input wire logic symbol_rx_clock,
  input wire symbol_port_pkg::rx_pins_t symbol_rx_bits,
  input wire logic symbol_rx_bits_oe,
  input wire logic symbol_tx_clock,
  input wire logic [symbol_port_pkg::SYM_W-1:0] tx_word,
  output symbol_port_pkg::tx_pins_t symbol_tx_bits,
  output int unstable_cnt
);
  import symbol_port_pkg::*;
  logic [4:0] last_rx = IDLE_SYM;
  logic [4:0] rise_val;
  logic rise_seen = 1'b0;
  logic [4:0] rx_q[$];

  // ----------------------------------------
  // receive side
  // ----------------------------------------
  initial unstable_cnt = 0;
  // released lines carry nothing, so only driven values are taken
  always @(posedge symbol_rx_clock) begin
    // lines launch on this very edge, so read them once they have settled
    #1;
    rise_val = {symbol_rx_bits.msb, symbol_rx_bits.low};
    rise_seen = 1'b1;
    if (symbol_rx_bits_oe === 1'b1 && rise_val !== last_rx) begin
      rx_q.push_back(rise_val);
      last_rx = rise_val;
    end
  end
  // lines must hold between rising edges of the receive clock
  always @(negedge symbol_rx_clock) begin
    if (rise_seen && symbol_rx_bits_oe === 1'b1 &&
        {symbol_rx_bits.msb, symbol_rx_bits.low} !== rise_val) begin
      unstable_cnt++;
    end
  end

  // ----------------------------------------
  // transmit side
  // ----------------------------------------
  // idle between frames is our job, the device inserts nothing
  initial symbol_tx_bits = IDLE_SYM;
  // launch on the falling edge so lines are settled at each rise
  always @(negedge symbol_tx_clock) begin
    symbol_tx_bits <= tx_word;
  end
endmodule

//--- testbench/symbol_mode_data_port_bench.sv
// self-checking bench for the symbol mode data port
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin num_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module symbol_mode_data_port_bench;
  import symbol_port_pkg::*;
  localparam int REF_PERIOD = 48;
  logic core_clk = 1'b0;
  logic sym_ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [4:0] media_rx_symbol = 5'h00;
  logic media_rx_valid = 1'b0;
  logic media_rx_ready, media_tx_valid, tx_overrun;
  logic [4:0] media_tx_symbol;
  logic [4:0] mgmt_address = 5'h01;
  logic rx_output_float_request = 1'b0;
  logic tx_enable_pin = 1'b0;
  logic symbol_rx_clock, symbol_rx_clock_oe, symbol_rx_bits_oe, symbol_tx_clock;
  logic rx_data_valid_pin, collision_pin;
  rx_pins_t symbol_rx_bits;
  tx_pins_t symbol_tx_bits;
  logic [4:0] tx_word = 5'h1f;
  int unstable_cnt;
  int num_errors = 0;
  int total_checks = 0;

  always #25 core_clk = ~core_clk;
  always #(REF_PERIOD / 2) sym_ref_clk = ~sym_ref_clk;

  symbol_mode_data_port i_dut (
    .core_clk(core_clk), .srst(srst), .sym_ref_clk(sym_ref_clk),
    .media_rx_symbol(media_rx_symbol), .media_rx_valid(media_rx_valid),
    .media_rx_ready(media_rx_ready), .media_tx_symbol(media_tx_symbol),
    .media_tx_valid(media_tx_valid), .tx_overrun(tx_overrun),
    .mgmt_address(mgmt_address), .rx_output_float_request(rx_output_float_request),
    .symbol_rx_clock(symbol_rx_clock), .symbol_rx_clock_oe(symbol_rx_clock_oe),
    .symbol_rx_bits(symbol_rx_bits), .symbol_rx_bits_oe(symbol_rx_bits_oe),
    .symbol_tx_clock(symbol_tx_clock), .symbol_tx_bits(symbol_tx_bits),
    .tx_enable_pin(tx_enable_pin), .rx_data_valid_pin(rx_data_valid_pin),
    .collision_pin(collision_pin)
  );

  mac_symbol_model i_mac (
    .symbol_rx_clock(symbol_rx_clock), .symbol_rx_bits(symbol_rx_bits),
    .symbol_rx_bits_oe(symbol_rx_bits_oe), .symbol_tx_clock(symbol_tx_clock),
    .tx_word(tx_word), .symbol_tx_bits(symbol_tx_bits), .unstable_cnt(unstable_cnt)
  );

  // ----------------------------------------
  // always-on watch of the unused framing pins
  // ----------------------------------------
  always @(negedge core_clk) begin
    if (!srst) begin
      `CHK("rx data valid pin", 1'b0, rx_data_valid_pin)
      `CHK("collision pin", 1'b0, collision_pin)
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic check_clocks;
    realtime t0;
    begin
      @(posedge symbol_rx_clock) t0 = $realtime;
      @(posedge symbol_rx_clock);
      `CHK("rx clock period", 2 * REF_PERIOD, int'($realtime - t0))
      @(posedge symbol_tx_clock) t0 = $realtime;
      @(posedge symbol_tx_clock);
      `CHK("tx clock period", 2 * REF_PERIOD, int'($realtime - t0))
      @(negedge core_clk);
    end
  endtask

  // back-to-back words, valid held while the buffer refuses
  task automatic rx_burst;
    logic [4:0] seq[6];
    logic full;
    int n;
    begin
      seq = '{5'h01, 5'h10, 5'h0a, 5'h15, 5'h1e, 5'h00};
      full = 1'b0;
      i_mac.rx_q.delete();
      foreach (seq[k]) begin
        media_rx_symbol = seq[k];
        media_rx_valid = 1'b1;
        n = 0;
        while (media_rx_ready !== 1'b1 && n < 200) begin
          @(negedge core_clk);
          full = 1'b1;
          n++;
        end
        @(negedge core_clk);
      end
      media_rx_valid = 1'b0;
      n = 0;
      while (i_mac.rx_q.size() < 6 && n < 400) begin
        @(negedge core_clk);
        n++;
      end
      `CHK("rx buffer refused", 1'b1, full)
      `CHK("rx symbol count", 6, i_mac.rx_q.size())
      foreach (seq[k]) `CHK("rx symbol", seq[k], i_mac.rx_q[k])
      `CHK("rx line stability", 0, unstable_cnt)
    end
  endtask

  task automatic wait_tx;
    int n;
    begin
      n = 0;
      do begin
        @(negedge core_clk);
        n++;
      end while (media_tx_valid !== 1'b1 && n < 50);
    end
  endtask

  // every code, with the transmit enable toggled under it
  task automatic tx_sweep;
    begin
      for (int v = 0; v < 32; v++) begin
        tx_word = v[4:0];
        tx_enable_pin = v[1];
        repeat (8) wait_tx();
        `CHK("tx symbol", v[4:0], media_tx_symbol)
      end
      // symbols come faster than the toggle handshake drains them, so drops are flagged
      `CHK("tx overrun", 1'b1, tx_overrun)
    end
  endtask

  task automatic wait_oe(input logic ex);
    int n;
    begin
      n = 0;
      while (symbol_rx_bits_oe !== ex && n < 40) begin
        @(negedge core_clk);
        n++;
      end
      repeat (2) @(negedge core_clk);
    end
  endtask

  task automatic float_test;
    begin
      rx_output_float_request = 1'b1;
      wait_oe(1'b0);
      `CHK("float bits oe", 1'b0, symbol_rx_bits_oe)
      `CHK("float clock oe", 1'b0, symbol_rx_clock_oe)
      rx_output_float_request = 1'b0;
      wait_oe(1'b1);
      `CHK("driven bits oe", 1'b1, symbol_rx_bits_oe)
      `CHK("driven clock oe", 1'b1, symbol_rx_clock_oe)
      mgmt_address = 5'h00;
      wait_oe(1'b0);
      `CHK("address zero bits oe", 1'b0, symbol_rx_bits_oe)
      mgmt_address = 5'h01;
      wait_oe(1'b1);
      `CHK("address set bits oe", 1'b1, symbol_rx_bits_oe)
    end
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic end_sim;
    begin
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask

  // whole run is about 80 us, so this only trips on a hang
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end

  initial begin
    repeat (20) @(negedge core_clk);
    srst = 1'b0;
    repeat (10) @(negedge core_clk);
    check_clocks();
    rx_burst();
    tx_sweep();
    float_test();
    end_sim();
  end
endmodule
